/* dma_and_interrupt_request_logic.sv */
// Purpose: DMA request and interrupt request logic of an acquisition board
// Assumes: Pins asynchronous to mclk; cfg and host strobes on mclk
// Notes: Pins pass three flip-flops and a second/third agreement filter
`include "req_defs.svh"

module dma_and_interrupt_request_logic (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // FIFO status pins
  input wire logic adc_fifo_nonempty_n,
  input wire logic adc_fifo_halffull_n,
  input wire logic out_fifo_full_n,
  input wire logic out_fifo_halffull_n,
  // Timer trigger pin
  input wire logic timer_trigger_n,
  // Host DMA controller pins
  input wire logic dma_ack_a,
  input wire logic dma_ack_b,
  input wire logic dma_tc,
  output logic dma_req_a,
  output logic dma_req_b,
  // Acquisition logic
  input wire logic acq_done,
  // Host configuration and strobes
  input wire req_pkg::req_cfg_t cfg,
  input wire req_pkg::host_wr_t host_wr,
  // Results
  output logic irq,
  output logic dac_update,
  output logic dac_target,
  output req_pkg::req_status_t status
);

  //----------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pins;
  logic [`PIN_COUNT-1:0] filt_q;
  logic [`PIN_COUNT-1:0] prev_q;

  // Idle level of every pin, one bit per synchroniser
  localparam logic [`PIN_COUNT-1:0] pin_idle = `PIN_RESET;

  // Gather pins into one vector
  assign pins = {dma_tc, dma_ack_b, dma_ack_a, timer_trigger_n,
                 out_fifo_halffull_n, out_fifo_full_n,
                 adc_fifo_halffull_n, adc_fifo_nonempty_n};

  // Falling and rising edge of a filtered pin
  function automatic logic fell(input logic p, input logic c);
    fell = p & ~c;
  endfunction

  function automatic logic rose(input logic p, input logic c);
    rose = ~p & c;
  endfunction

  // Three stages, change accepted when stages two and three agree
  // Each pin keeps its own flops so no vector has several writers
  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_sync
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic hold_q;
    logic last_q;
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        sync1_q <= pin_idle[i];
        sync2_q <= pin_idle[i];
        sync3_q <= pin_idle[i];
        hold_q <= pin_idle[i];
        last_q <= pin_idle[i];
      end else begin
        sync1_q <= pins[i];
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
        if (sync2_q == sync3_q) begin
          hold_q <= sync3_q;
        end
        last_q <= hold_q;
      end
    end
    assign filt_q[i] = hold_q;
    assign prev_q[i] = last_q;
  end

  //----------------------------------------------------------------
  // Decoded conditions and events
  //----------------------------------------------------------------
  logic adc_ne;
  logic adc_hf;
  logic out_nf;
  logic out_hf;
  logic ack_a;
  logic ack_b;
  logic timer_fall;
  logic ack_start;
  logic tc_rise;
  logic tc_a;
  logic tc_b;
  logic dual_out;

  // Levels, active high inside the block
  assign adc_ne = ~filt_q[`PIN_ADC_NE];
  assign adc_hf = ~filt_q[`PIN_ADC_HF];
  assign out_nf = filt_q[`PIN_OUT_FULL];
  assign out_hf = filt_q[`PIN_OUT_HF];
  assign ack_a = filt_q[`PIN_ACK_A];
  assign ack_b = filt_q[`PIN_ACK_B];
  assign dual_out = cfg.mode == req_pkg::DMA_DUAL_OUT;

  // Events from edges
  assign timer_fall = fell(prev_q[`PIN_TIMER], filt_q[`PIN_TIMER]);
  assign ack_start = rose(prev_q[`PIN_ACK_A], ack_a) |
                     rose(prev_q[`PIN_ACK_B], ack_b);
  assign tc_rise = rose(prev_q[`PIN_TC], filt_q[`PIN_TC]);

  // Terminal count belongs to the acknowledged or active channel
  assign tc_a = tc_rise & (dual_out ? ack_a : ~status.chan_b_active);
  assign tc_b = tc_rise & (dual_out ? ack_b : status.chan_b_active);

  //----------------------------------------------------------------
  // Flags
  //----------------------------------------------------------------
  logic conv_ne_q;
  logic conv_hf_q;
  logic ne_armed_q;
  logic hf_armed_q;
  logic acq_q;
  logic tca_q;
  logic tcb_q;
  logic tmr_q;
  logic chan_b_q;
  logic conv_clr;
  logic ne_set;
  logic hf_set;

  // Conversion interrupts re-arm after each read or clear
  assign conv_clr = host_wr.adc_fifo_read | host_wr.acq_clear;
  assign ne_set = adc_ne & ne_armed_q;
  assign hf_set = adc_hf & hf_armed_q;

  // Conversion flags, set wins over clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conv_ne_q <= `FLAG_RESET;
      conv_hf_q <= `FLAG_RESET;
      ne_armed_q <= `ARM_RESET;
      hf_armed_q <= `ARM_RESET;
    end else begin
      if (ne_set) begin
        conv_ne_q <= 1'b1;
        ne_armed_q <= 1'b0;
      end else if (conv_clr) begin
        conv_ne_q <= 1'b0;
        ne_armed_q <= 1'b1;
      end
      if (hf_set) begin
        conv_hf_q <= 1'b1;
        hf_armed_q <= 1'b0;
      end else if (conv_clr) begin
        conv_hf_q <= 1'b0;
        hf_armed_q <= 1'b1;
      end
    end
  end

  // Acquisition complete, dropped only by the acquisition clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acq_q <= `FLAG_RESET;
    end else if (acq_done) begin
      acq_q <= 1'b1;
    end else if (host_wr.acq_clear) begin
      acq_q <= 1'b0;
    end
  end

  // Terminal count flags, cleared by writing zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tca_q <= `FLAG_RESET;
      tcb_q <= `FLAG_RESET;
    end else begin
      if (tc_a) begin
        tca_q <= 1'b1;
      end else if (host_wr.tc_clear_a &&
                   host_wr.data == `TC_CLEAR_VALUE) begin
        tca_q <= 1'b0;
      end
      if (tc_b) begin
        tcb_q <= 1'b1;
      end else if (host_wr.tc_clear_b &&
                   host_wr.data == `TC_CLEAR_VALUE) begin
        tcb_q <= 1'b0;
      end
    end
  end

  // Timer update request, set by trigger, cleared by write or ack
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tmr_q <= `FLAG_RESET;
    end else if (timer_fall) begin
      tmr_q <= 1'b1;
    end else if (host_wr.timer_clear || ack_start) begin
      tmr_q <= 1'b0;
    end
  end

  // Active channel of a dual stream, swapped at each terminal count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chan_b_q <= `FLAG_RESET;
    end else if (cfg.mode != req_pkg::DMA_DUAL_STREAM) begin
      chan_b_q <= 1'b0;
    end else if (tc_rise) begin
      chan_b_q <= ~chan_b_q;
    end
  end

  //----------------------------------------------------------------
  // Converter update and target
  //----------------------------------------------------------------
  logic upd_q;
  logic tgt_q;
  logic il_next_q;

  // Both converters update on a trigger only with waveform enabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= timer_fall & cfg.wave_gen_en;
    end
  end

  // Converter that receives the acknowledged output word
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tgt_q <= 1'b0;
      il_next_q <= 1'b0;
    end else begin
      unique case (cfg.mode)
        req_pkg::DMA_INTERLEAVE: begin
          if (rose(prev_q[`PIN_ACK_A], ack_a)) begin
            tgt_q <= il_next_q;
            il_next_q <= ~il_next_q;
          end
        end
        req_pkg::DMA_DUAL_OUT: begin
          il_next_q <= 1'b0;
          if (rose(prev_q[`PIN_ACK_A], ack_a)) begin
            tgt_q <= 1'b0;
          end else if (rose(prev_q[`PIN_ACK_B], ack_b)) begin
            tgt_q <= 1'b1;
          end
        end
        default: begin
          il_next_q <= 1'b0;
          tgt_q <= 1'b0;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // DMA requests
  //----------------------------------------------------------------
  logic adc_src;
  logic out_src;
  logic dma_on;

  // Enabled causes for input and output transfers
  assign adc_src = (cfg.req_en[`REQ_ADC_NE] & adc_ne) |
                   (cfg.req_en[`REQ_ADC_HF] & adc_hf);
  assign out_src = (cfg.req_en[`REQ_OUT_NF] & out_nf) |
                   (cfg.req_en[`REQ_OUT_HF] & out_hf) |
                   (cfg.req_en[`REQ_TIMER] & tmr_q);
  assign dma_on = cfg.mode != req_pkg::DMA_OFF;

  // Route to the selected channel, withdrawn during acknowledge
  always_comb begin
    dma_req_a = 1'b0;
    dma_req_b = 1'b0;
    unique case (cfg.mode)
      req_pkg::DMA_OFF: begin
        dma_req_a = 1'b0;
      end
      req_pkg::DMA_SINGLE, req_pkg::DMA_INTERLEAVE: begin
        dma_req_a = (adc_src | out_src) & cfg.chan_a_en & ~ack_a;
      end
      req_pkg::DMA_DUAL_STREAM: begin
        dma_req_a = (adc_src | out_src) & ~chan_b_q &
                    cfg.chan_a_en & ~ack_a;
        dma_req_b = (adc_src | out_src) & chan_b_q &
                    cfg.chan_b_en & ~ack_b;
      end
      req_pkg::DMA_DUAL_OUT: begin
        dma_req_a = (adc_src | out_src) & cfg.chan_a_en & ~ack_a;
        dma_req_b = out_src & cfg.chan_b_en & ~ack_b;
      end
      default: begin
        dma_req_a = 1'b0;
        dma_req_b = 1'b0;
      end
    endcase
    if (!dma_on) begin
      dma_req_a = 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Interrupt and status
  //----------------------------------------------------------------
  logic [6:0] pend;
  logic irq_q;
  req_pkg::req_status_t stat_q;

  // Pending causes in fixed bit order
  always_comb begin
    pend = 7'h00;
    pend[`SRC_CONV_NE] = conv_ne_q;
    pend[`SRC_CONV_HF] = conv_hf_q;
    pend[`SRC_ACQ] = acq_q;
    pend[`SRC_TC] = tca_q | tcb_q;
    pend[`SRC_TIMER] = tmr_q;
    pend[`SRC_OUT_NF] = out_nf;
    pend[`SRC_OUT_HF] = out_hf;
  end

  // Registered interrupt and status word
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      stat_q <= '0;
    end else begin
      irq_q <= |(pend & cfg.int_en);
      stat_q.pending <= pend;
      stat_q.term_count_flag_a <= tca_q;
      stat_q.term_count_flag_b <= tcb_q;
      stat_q.timer_update_request <= tmr_q;
      stat_q.acq_complete_flag <= acq_q;
      stat_q.chan_b_active <= chan_b_q;
    end
  end

  assign irq = irq_q;
  assign status = stat_q;
  assign dac_update = upd_q;
  assign dac_target = tgt_q;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  a_dma_off_quiet: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfg.mode == req_pkg::DMA_OFF |-> !dma_req_a && !dma_req_b)
    else $error("request while DMA off");

  a_single_a_only: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfg.mode == req_pkg::DMA_SINGLE |-> !dma_req_b)
    else $error("channel B used in single mode");

  a_adc_request: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfg.mode == req_pkg::DMA_SINGLE && cfg.chan_a_en &&
    cfg.req_en[`REQ_ADC_NE] && adc_ne && !ack_a |-> dma_req_a)
    else $error("missing input FIFO request");

  a_ack_drops_req: assert property (
    @(posedge mclk) disable iff (!resetn)
    ack_a |-> !dma_req_a)
    else $error("request held during acknowledge");

  a_tc_zero_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    host_wr.tc_clear_a && host_wr.data == 8'h00 && !tc_a
    |=> !tca_q ##1 !stat_q.term_count_flag_a)
    else $error("terminal count A not cleared");

  a_tc_nonzero_keep: assert property (
    @(posedge mclk) disable iff (!resetn)
    tcb_q && host_wr.data != 8'h00 |=> tcb_q)
    else $error("terminal count B lost");

  a_acq_sticky: assert property (
    @(posedge mclk) disable iff (!resetn)
    acq_done ##1 !host_wr.acq_clear [*2] |-> acq_q ##1 stat_q.pending[2])
    else $error("acquisition flag not held");

  a_timer_edge: assert property (
    @(posedge mclk) disable iff (!resetn)
    timer_fall |=> tmr_q && dac_update == $past(cfg.wave_gen_en))
    else $error("timer trigger mishandled");

  a_timer_ack_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    ack_start && !timer_fall |=> !tmr_q)
    else $error("timer request survives acknowledge");

  a_chan_swap: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfg.mode == req_pkg::DMA_DUAL_STREAM && tc_rise
    |=> chan_b_q != $past(chan_b_q))
    else $error("channel not swapped at terminal count");

  a_conv_read_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    host_wr.adc_fifo_read && !ne_set |=> !conv_ne_q)
    else $error("read did not clear conversion flag");

  a_irq_enabled: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pend & cfg.int_en) != 7'h00 |=> irq && stat_q.pending != 7'h00)
    else $error("enabled cause without interrupt");

endmodule

/* req_defs.svh */
// Purpose: Constants of the DMA and interrupt request logic
// Assumes: Included by bare name
// Notes: Pin and source indices, reset values
`ifndef REQ_DEFS_SVH
`define REQ_DEFS_SVH
`define PIN_COUNT 8
`define PIN_ADC_NE 0
`define PIN_ADC_HF 1
`define PIN_OUT_FULL 2
`define PIN_OUT_HF 3
`define PIN_TIMER 4
`define PIN_ACK_A 5
`define PIN_ACK_B 6
`define PIN_TC 7
`define PIN_RESET 8'h1F
`define REQ_ADC_NE 0
`define REQ_ADC_HF 1
`define REQ_OUT_NF 2
`define REQ_OUT_HF 3
`define REQ_TIMER 4
`define SRC_CONV_NE 0
`define SRC_CONV_HF 1
`define SRC_ACQ 2
`define SRC_TC 3
`define SRC_TIMER 4
`define SRC_OUT_NF 5
`define SRC_OUT_HF 6
`define FLAG_RESET 1'b0
`define ARM_RESET 1'b1
`define TC_CLEAR_VALUE 8'h00
`endif

/* req_pkg.sv */
// Purpose: Types of the DMA and interrupt request logic
// Assumes: Nothing
// Notes: Used with package-scoped names only
package req_pkg;

  // DMA operating modes
  typedef enum logic [2:0] {
    DMA_OFF,
    DMA_SINGLE,
    DMA_INTERLEAVE,
    DMA_DUAL_STREAM,
    DMA_DUAL_OUT
  } dma_mode_t;

  // Static configuration from the command registers
  typedef struct packed {
    dma_mode_t mode;
    logic chan_a_en;
    logic chan_b_en;
    logic wave_gen_en;
    logic [4:0] req_en;
    logic [6:0] int_en;
  } req_cfg_t;

  // One-cycle host write and read strobes
  typedef struct packed {
    logic adc_fifo_read;
    logic acq_clear;
    logic timer_clear;
    logic tc_clear_a;
    logic tc_clear_b;
    logic [7:0] data;
  } host_wr_t;

  // Status seen by the host
  typedef struct packed {
    logic [6:0] pending;
    logic term_count_flag_a;
    logic term_count_flag_b;
    logic timer_update_request;
    logic acq_complete_flag;
    logic chan_b_active;
  } req_status_t;

endpackage

/* host_dma_model.sv */
// Purpose: Host DMA controller model facing the request logic
// Assumes: Requests are sampled just after rising mclk edges
// Notes: One transfer at a time; dly sets how fast it answers
module host_dma_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Bench control
  input wire logic serve,
  input wire logic tc_on,
  input wire logic [3:0] dly,
  // Request pins
  input wire logic req_a,
  input wire logic req_b,
  // Answer pins
  output logic ack_a,
  output logic ack_b,
  output logic tc,
  output logic fifo_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic use_b;
  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  // Ack four cycles, then a gap so the filter sees ack low again
  initial begin
    {ack_a, ack_b, tc, fifo_rd, use_b} = 5'h00;
    forever begin
      @(posedge mclk);
      #2;
      if (resetn && serve && (req_a || req_b)) begin
        use_b = !req_a;
        repeat (dly) @(posedge mclk);
        #2;
        {ack_a, ack_b, tc, fifo_rd} = {!use_b, use_b, tc_on, !use_b};
        @(posedge mclk);
        #2;
        fifo_rd = 1'h0;
        repeat (3) @(posedge mclk);
        #2;
        {ack_a, ack_b, tc} = 3'h0;
        repeat (3) @(posedge mclk);
      end
    end
  end
endmodule

/* dma_and_interrupt_request_logic_tb.sv */
// Purpose: Self-checking bench of the DMA and interrupt request logic
// Assumes: Inputs change 2 ns after rising mclk
// Notes: Table of request cases first, then flag and channel cases
module dma_and_interrupt_request_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] pins;
    logic [4:0] en;
    req_pkg::dma_mode_t mode;
    logic [1:0] exp;
  } row_t;
  logic mclk, resetn, timer_trigger_n, acq_done, serve, tc_on, fifo_rd;
  logic [3:0] pins, dly;
  logic dma_ack_a, dma_ack_b, dma_tc, dma_req_a, dma_req_b;
  logic irq, dac_update, dac_target;
  req_pkg::req_cfg_t cfg;
  req_pkg::host_wr_t wr, host_wr;
  req_pkg::req_status_t status;
  int mismatches, check_count, n;
  row_t rows [8];

  // Host strobes merged with the model's FIFO reads
  always_comb begin
    host_wr = wr;
    host_wr.adc_fifo_read = wr.adc_fifo_read | fifo_rd;
  end

  dma_and_interrupt_request_logic dut_u (
    .mclk(mclk), .resetn(resetn),
    .adc_fifo_nonempty_n(pins[3]), .adc_fifo_halffull_n(pins[2]),
    .out_fifo_full_n(pins[1]), .out_fifo_halffull_n(pins[0]),
    .timer_trigger_n(timer_trigger_n),
    .dma_ack_a(dma_ack_a), .dma_ack_b(dma_ack_b), .dma_tc(dma_tc),
    .dma_req_a(dma_req_a), .dma_req_b(dma_req_b), .acq_done(acq_done),
    .cfg(cfg), .host_wr(host_wr), .irq(irq), .dac_update(dac_update),
    .dac_target(dac_target), .status(status)
  );

  host_dma_model model_u (
    .mclk(mclk), .resetn(resetn), .serve(serve), .tc_on(tc_on),
    .dly(dly), .req_a(dma_req_a), .req_b(dma_req_b), .ack_a(dma_ack_a),
    .ack_b(dma_ack_b), .tc(dma_tc), .fifo_rd(fifo_rd)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #2;
  endtask

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe bits: read, acq clear, timer clear, clear A, clear B
  task automatic strobe(input logic [4:0] sel, input logic [7:0] d);
    wr = req_pkg::host_wr_t'({sel, d});
    cyc(1);
    wr = '0;
    cyc(3);
  endtask

  task automatic trig(output int cnt);
    cnt = 0;
    timer_trigger_n = 1'h0;
    for (int i = 0; i < 12; i++) begin
      if (i == 8) timer_trigger_n = 1'h1;
      cyc(1);
      cnt += (dac_update === 1'h1);
    end
  endtask

  // One served transfer, bounded waits for ack rise and fall
  task automatic xfer();
    serve = 1'h1;
    for (int i = 0; i < 40 && !(dma_ack_a || dma_ack_b); i++) cyc(1);
    for (int i = 0; i < 20 && (dma_ack_a || dma_ack_b); i++) cyc(1);
    serve = 1'h0;
    cyc(8);
  endtask

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Clock of 100 ns
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // Watchdog at several times the planned run length
  initial begin
    #600000;
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {resetn, timer_trigger_n, acq_done, serve, tc_on} = 5'h08;
    {dly, pins, cfg, wr} = '0;
    dly = 4'h1;
    pins = 4'hC;
    mismatches = 0;
    check_count = 0;
    rows = '{
      '{4'h4, 5'h01, req_pkg::DMA_SINGLE, 2'h2},
      '{4'h8, 5'h02, req_pkg::DMA_SINGLE, 2'h2},
      '{4'h4, 5'h02, req_pkg::DMA_SINGLE, 2'h0},
      '{4'hE, 5'h04, req_pkg::DMA_SINGLE, 2'h2},
      '{4'hD, 5'h08, req_pkg::DMA_SINGLE, 2'h2},
      '{4'h3, 5'h0F, req_pkg::DMA_OFF, 2'h0},
      '{4'hE, 5'h04, req_pkg::DMA_DUAL_OUT, 2'h3},
      '{4'h4, 5'h01, req_pkg::DMA_DUAL_OUT, 2'h2}};
    cyc(6);
    resetn = 1'h1;
    cyc(1);
    // Output FIFO filters leave reset as not full and under half
    check("status", status, 12'hC00);
    check("outputs", {dma_req_a, dma_req_b, irq, dac_update}, 12'h0);
    cfg.chan_a_en = 1'h1;
    cfg.chan_b_en = 1'h1;
    foreach (rows[i]) begin
      pins = rows[i].pins;
      cfg.req_en = rows[i].en;
      cfg.mode = rows[i].mode;
      cyc(8);
      check($sformatf("req row %0d", i), {dma_req_a, dma_req_b}, rows[i].exp);
    end
    // Timer trigger, clear, waveform off, DMA acknowledge
    pins = 4'hC;
    cfg.mode = req_pkg::DMA_SINGLE;
    cfg.req_en = 5'h00;
    cfg.int_en = 7'h10;
    cfg.wave_gen_en = 1'h1;
    strobe(5'h0F, 8'h00);
    trig(n);
    check("update count", n[11:0], 12'h001);
    cyc(2);
    check("timer flag", {status.timer_update_request, irq}, 12'h3);
    strobe(5'h04, 8'h00);
    check("timer clear", {status.timer_update_request, irq}, 12'h0);
    cfg.wave_gen_en = 1'h0;
    trig(n);
    check("update off", n[11:0], 12'h000);
    cyc(2);
    check("timer set", status.timer_update_request, 12'h1);
    cfg.req_en = 5'h10;
    cyc(1);
    check("timer req", {dma_req_a, dma_req_b}, 12'h2);
    xfer();
    check("timer ack", status.timer_update_request, 12'h0);
    // Dual stream: A first, swap at each terminal count
    cfg.mode = req_pkg::DMA_DUAL_STREAM;
    cfg.req_en = 5'h01;
    cfg.int_en = 7'h08;
    pins = 4'h4;
    tc_on = 1'h1;
    cyc(8);
    check("stream start", {dma_req_a, dma_req_b}, 12'h2);
    xfer();
    check("stream swap", {status.chan_b_active, status.term_count_flag_a,
                          irq, dma_req_a, dma_req_b}, 12'h1D);
    xfer();
    check("stream back", {status.chan_b_active, status.term_count_flag_b,
                          dma_req_a, dma_req_b}, 12'h6);
    strobe(5'h02, 8'h05);
    check("tc keep", status.term_count_flag_a, 12'h1);
    strobe(5'h02, 8'h00);
    check("tc clear", {status.term_count_flag_a, status.term_count_flag_b},
          12'h1);
    // Interleaved output alternates converters from 0
    cfg.mode = req_pkg::DMA_INTERLEAVE;
    cfg.req_en = 5'h04;
    pins = 4'hE;
    tc_on = 1'h0;
    dly = 4'h6;
    for (int i = 0; i < 3; i++) begin
      xfer();
      check("target", dac_target, {11'h000, i[0]});
    end
    // Acquisition flag and conversion interrupts
    cfg.mode = req_pkg::DMA_OFF;
    cfg.req_en = 5'h00;
    cfg.int_en = 7'h04;
    pins = 4'hC;
    acq_done = 1'h1;
    cyc(1);
    acq_done = 1'h0;
    cyc(3);
    check("acq", {status.acq_complete_flag, status.pending[2], irq},
          12'h7);
    cfg.int_en = 7'h00;
    cyc(3);
    check("irq masked", irq, 12'h0);
    strobe(5'h04, 8'h00);
    check("acq keep", status.acq_complete_flag, 12'h1);
    strobe(5'h08, 8'h00);
    check("acq clear", status.acq_complete_flag, 12'h0);
    pins = 4'h4;
    cyc(8);
    check("conv set", status.pending[0], 12'h1);
    pins = 4'hC;
    cyc(8);
    check("conv hold", status.pending[0], 12'h1);
    strobe(5'h10, 8'h00);
    check("conv read", status.pending[0], 12'h0);
    pins = 4'h4;
    cyc(8);
    pins = 4'hC;
    cyc(8);
    strobe(5'h08, 8'h00);
    check("conv acq clear", status.pending[0], 12'h0);
    // Reset in mid-run drops every flag
    resetn = 1'h0;
    cyc(2);
    check("reset", status, 12'h000);
    resetn = 1'h1;
    cyc(1);
    check("release", status, 12'hC00);
    check("release out", {dma_req_a, dma_req_b, irq, dac_update}, 12'h0);
    cyc(8);
    check("settled", status, 12'h000);
    finish_test();
  end
endmodule
